// *** common/pdl_regs.vh ***
// register map, field positions, reset values and timing counts of the
// power-down and low-power idle controller; include once per design file.
`ifndef PDL_REGS_VH
`define PDL_REGS_VH
// standard registers
`define PDL_STD_BASIC 5'h00
`define PDL_STD_AUX 5'h1B
`define PDL_BASIC_PD 11
`define PDL_BASIC_ISO 10
`define PDL_BASIC_RST_AN 9
`define PDL_AUX_XTAL_OFF 0
`define PDL_AUX_REG_EN_N 1
// extended spaces
`define PDL_MMD_PROTECTED 5'h01
`define PDL_MMD_VENDOR 5'h02
`define PDL_MMD_PCS 5'h03
`define PDL_MMD_AN 5'h07
`define PDL_PCS_CTRL1 16'h0000
`define PDL_PCS_STAT1 16'h0001
`define PDL_EEE_ADV 16'h003C
`define PDL_EEE_LPA 16'h003D
`define PDL_VND_SPD 16'h0010
`define PDL_VND_COMMON 16'h0011
`define PDL_VND_AFED 16'h0012
`define PDL_PCS_CLK_STOP 10
`define PDL_STAT_RX_LPI 8
`define PDL_STAT_TX_LPI 9
`define PDL_ADV_100 1
`define PDL_ADV_1000 2
`define PDL_SPD_OVERRIDE 0
`define PDL_SPD_PLL_DIS 1
`define PDL_COMMON_REFCLK_EN 0
`define PDL_AFED_RED_AMP_DIS 0
// reset values
`define PDL_ADV_RST 16'h0006
`define PDL_COMMON_RST 16'h0001
// strap and line codes
`define PDL_STRAP_CPD 4'h7
`define PDL_LPI_DATA 8'h01
// timing
`define PDL_CLK_MHZ 100
`define PDL_TICK_US 1
`define PDL_REFRESH_PERIOD_US 20000
`define PDL_REFRESH_BURST_US 200
`define PDL_IDLE_CLK_MIN 9
`endif

// *** hw/pdl_sat_cnt.v ***
// saturating counter of events, cleared synchronously.
// assumes inc_i and clr_i are single-cycle terms on the same clock.
module pdl_sat_cnt #(
  parameter W = 4,
  parameter LIMIT = 9
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire clr_i,
  input wire inc_i,
  output reg [W-1:0] cnt_o,
  output reg hit_o
);
  localparam [W-1:0] LIM = LIMIT;
  reg [W-1:0] cnt_next;

  always @* begin
    cnt_next = cnt_o;
    if (clr_i) begin
      cnt_next = {W{1'b0}};
    end else if (inc_i && cnt_o != LIM) begin
      cnt_next = cnt_o + 1'b1;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_o <= {W{1'b0}};
      hit_o <= 1'b0;
    end else begin
      cnt_o <= cnt_next;
      hit_o <= (cnt_next == LIM);
    end
  end
endmodule

// *** hw/pdl_top.v ***
// power-down and low-power idle controller of a gigabit copper transceiver.
// assumes the management access port runs on clk_sys_i; MAC transmit pins,
// the receive clock and the straps come from other domains and are synchronised.
`include "pdl_regs.vh"
module pdl_top #(
  parameter REFRESH_PERIOD_US = `PDL_REFRESH_PERIOD_US,
  parameter REFRESH_BURST_US = `PDL_REFRESH_BURST_US
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [3:0] strap_i,
  input wire mgmt_req_i,
  input wire mgmt_we_i,
  input wire mgmt_ext_i,
  input wire [4:0] mgmt_mmd_i,
  input wire [15:0] mgmt_addr_i,
  input wire [15:0] mgmt_wdata_i,
  input wire [15:0] partner_ability_i,
  input wire speed_1000_i,
  input wire tx_en_i,
  input wire tx_er_i,
  input wire [7:0] txd_i,
  input wire rx_clk_i,
  input wire line_sleep_i,
  input wire line_dv_i,
  input wire line_er_i,
  input wire [7:0] line_data_i,
  output reg mgmt_ack_o,
  output reg mgmt_err_o,
  output reg [15:0] mgmt_rdata_o,
  output reg spd_o,
  output reg chip_power_down_state_o,
  output reg int_clk_en_o,
  output reg pll_on_o,
  output reg xtal_on_o,
  output reg regulator_on_o,
  output reg tx_clk_run_o,
  output reg rx_clk_run_o,
  output reg refclk_pin_en_o,
  output reg reduced_amp_o,
  output reg eee_en_o,
  output reg tx_lpi_o,
  output reg rx_lpi_o,
  output reg refresh_o,
  output reg rx_dv_o,
  output reg rx_er_o,
  output reg [7:0] rxd_o
);
  localparam [3:0] ST_NORM = 4'h1;
  localparam [3:0] ST_SPD = 4'h2;
  localparam [3:0] ST_DEAD = 4'h4;
  localparam [3:0] ST_CPD = 4'h8;
  localparam [6:0] TICK_DIV = `PDL_CLK_MHZ * `PDL_TICK_US;
  localparam [14:0] PERIOD = REFRESH_PERIOD_US;
  localparam [14:0] BURST = REFRESH_BURST_US;

  function is_lpi_code;
    input en;
    input er;
    input [7:0] d;
    input gig;
    begin
      is_lpi_code = !en && er &&
        (gig ? (d == `PDL_LPI_DATA) : ({4'h0, d[3:0]} == `PDL_LPI_DATA));
    end
  endfunction

  // ==========================================================
  // synchronisers for pins from other domains
  // ==========================================================
  reg [14:0] sync1_reg;
  reg [14:0] sync2_reg;
  reg rx_clk_d_reg;
  reg strap_taken_reg;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync1_reg <= 15'h0000;
      sync2_reg <= 15'h0000;
      rx_clk_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {strap_i, rx_clk_i, tx_en_i, tx_er_i, txd_i};
      sync2_reg <= sync1_reg;
      rx_clk_d_reg <= sync2_reg[10];
    end
  end

  wire [3:0] strap_s = sync2_reg[14:11];
  wire rx_clk_rise = sync2_reg[10] && !rx_clk_d_reg;
  wire tx_en_s = sync2_reg[9];
  wire tx_er_s = sync2_reg[8];
  wire [7:0] txd_s = sync2_reg[7:0];

  // ==========================================================
  // configuration registers
  // ==========================================================
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [15:0] basic_reg;
  reg [15:0] aux_reg;
  reg [15:0] pcs_ctrl_reg;
  reg [15:0] adv_reg;
  reg [15:0] spd_ctrl_reg;
  reg [15:0] common_reg;
  reg [15:0] afed_reg;
  reg eee_en_reg;
  reg pll_off_reg;
  reg full_rst_reg;
  reg ack_next;
  reg err_next;
  reg [15:0] rdata_next;

  wire cfg_rst = rst_i || full_rst_reg;
  wire in_spd = state_reg[1];
  wire override = spd_ctrl_reg[`PDL_SPD_OVERRIDE];
  wire live = state_reg[0] || state_reg[1];
  wire std_hit = !mgmt_ext_i;
  wire mmd_ok = !in_spd ||
    (override && mgmt_mmd_i != `PDL_MMD_PROTECTED);
  wire acc_ok = std_hit || mmd_ok;
  wire wr = mgmt_req_i && mgmt_we_i && live && acc_ok;
  wire wr_basic = wr && std_hit && mgmt_addr_i[4:0] == `PDL_STD_BASIC;
  wire wr_aux = wr && std_hit && mgmt_addr_i[4:0] == `PDL_STD_AUX;
  wire wr_pcs = wr && !std_hit && mgmt_mmd_i == `PDL_MMD_PCS &&
    mgmt_addr_i == `PDL_PCS_CTRL1;
  wire wr_adv = wr && !std_hit && mgmt_mmd_i == `PDL_MMD_AN &&
    mgmt_addr_i == `PDL_EEE_ADV;
  wire wr_vnd = wr && !std_hit && mgmt_mmd_i == `PDL_MMD_VENDOR;
  wire an_restart = wr_basic && mgmt_wdata_i[`PDL_BASIC_RST_AN];

  // registers are reset only by the pin or the PLL-off exit
  always @(posedge clk_sys_i) begin
    if (cfg_rst) begin
      basic_reg <= 16'h0000;
      aux_reg <= 16'h0000;
      pcs_ctrl_reg <= 16'h0000;
      adv_reg <= `PDL_ADV_RST;
      spd_ctrl_reg <= 16'h0000;
      common_reg <= `PDL_COMMON_RST;
      afed_reg <= 16'h0000;
      eee_en_reg <= 1'b1;
    end else begin
      if (wr_basic) begin
        basic_reg <= mgmt_wdata_i & ~(16'h0001 << `PDL_BASIC_RST_AN);
      end
      if (wr_aux) begin
        aux_reg <= mgmt_wdata_i;
      end
      if (wr_pcs) begin
        pcs_ctrl_reg <= mgmt_wdata_i;
      end
      if (wr_adv) begin
        adv_reg <= mgmt_wdata_i;
      end
      if (wr_vnd && mgmt_addr_i == `PDL_VND_SPD) begin
        spd_ctrl_reg <= mgmt_wdata_i;
      end
      if (wr_vnd && mgmt_addr_i == `PDL_VND_COMMON) begin
        common_reg <= mgmt_wdata_i;
      end
      if (wr_vnd && mgmt_addr_i == `PDL_VND_AFED) begin
        afed_reg <= mgmt_wdata_i;
      end
      // advertisement takes effect only at an autoneg restart
      if (an_restart) begin
        eee_en_reg <= adv_reg[`PDL_ADV_1000] || adv_reg[`PDL_ADV_100];
      end
    end
  end

  // ==========================================================
  // read path
  // ==========================================================
  always @* begin
    rdata_next = 16'h0000;
    err_next = 1'b0;
    ack_next = mgmt_req_i && live;
    if (mgmt_req_i && !acc_ok) begin
      err_next = 1'b1;
    end else if (std_hit) begin
      case (mgmt_addr_i[4:0])
        `PDL_STD_BASIC: rdata_next = basic_reg;
        `PDL_STD_AUX: rdata_next = aux_reg;
        default: rdata_next = 16'h0000;
      endcase
    end else begin
      case ({mgmt_mmd_i, mgmt_addr_i})
        {`PDL_MMD_PCS, `PDL_PCS_CTRL1}: rdata_next = pcs_ctrl_reg;
        {`PDL_MMD_PCS, `PDL_PCS_STAT1}: begin
          rdata_next[`PDL_STAT_RX_LPI] = rx_lpi_o;
          rdata_next[`PDL_STAT_TX_LPI] = tx_lpi_o;
        end
        {`PDL_MMD_AN, `PDL_EEE_ADV}: rdata_next = adv_reg;
        {`PDL_MMD_AN, `PDL_EEE_LPA}: rdata_next = partner_ability_i;
        {`PDL_MMD_VENDOR, `PDL_VND_SPD}: rdata_next = spd_ctrl_reg;
        {`PDL_MMD_VENDOR, `PDL_VND_COMMON}: rdata_next = common_reg;
        {`PDL_MMD_VENDOR, `PDL_VND_AFED}: rdata_next = afed_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      mgmt_ack_o <= 1'b0;
      mgmt_err_o <= 1'b0;
      mgmt_rdata_o <= 16'h0000;
    end else begin
      mgmt_ack_o <= ack_next;
      mgmt_err_o <= ack_next && err_next;
      mgmt_rdata_o <= ack_next ? rdata_next : 16'h0000;
    end
  end

  // ==========================================================
  // power state machine
  // ==========================================================
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_NORM: begin
        if (basic_reg[`PDL_BASIC_PD]) begin
          state_next = ST_SPD;
        end
      end
      ST_SPD: begin
        if (pll_off_reg && aux_reg[`PDL_AUX_XTAL_OFF]) begin
          state_next = ST_DEAD;
        end else if (!basic_reg[`PDL_BASIC_PD]) begin
          state_next = ST_NORM;
        end
      end
      ST_DEAD: state_next = ST_DEAD;
      ST_CPD: state_next = ST_CPD;
      default: state_next = ST_NORM;
    endcase
  end

  // straps are caught once, at the third edge after release, past the synchroniser
  reg [1:0] strap_wait_reg;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= ST_NORM;
      strap_taken_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
      pll_off_reg <= 1'b0;
      full_rst_reg <= 1'b0;
    end else begin
      full_rst_reg <= 1'b0;
      if (!strap_taken_reg) begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
      if (!strap_taken_reg && strap_wait_reg == 2'h2) begin
        strap_taken_reg <= 1'b1;
        if (strap_s == `PDL_STRAP_CPD) begin
          state_reg <= ST_CPD;
        end
      end else begin
        state_reg <= state_next;
      end
      if (state_reg[0] && state_next[1]) begin
        pll_off_reg <= spd_ctrl_reg[`PDL_SPD_PLL_DIS];
      end
      if (state_reg[1] && state_next[0]) begin
        pll_off_reg <= 1'b0;
        full_rst_reg <= pll_off_reg;
      end
    end
  end

  // ==========================================================
  // low-power idle paths
  // ==========================================================
  // the MAC keeps the pattern nine gigabit clocks before stopping its clock,
  // so the sampled pattern is still seen after that clock halts
  wire tx_lpi_now = eee_en_reg && state_reg[0] &&
    is_lpi_code(tx_en_s, tx_er_s, txd_s, speed_1000_i);
  // leaving on the first non-sleep code keeps traffic flowing
  wire rx_lpi_now = eee_en_reg && state_reg[0] && line_sleep_i;
  wire any_lpi = tx_lpi_now || rx_lpi_now;
  wire idle_hit;

  pdl_sat_cnt #(
    .W(4),
    .LIMIT(`PDL_IDLE_CLK_MIN)
  ) u_rx_idle_cnt (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clr_i(!rx_lpi_now),
    .inc_i(rx_clk_rise),
    .cnt_o(),
    .hit_o(idle_hit)
  );

  // refresh cadence counted in microseconds; low limits used so both sit in range
  reg [6:0] div_reg;
  reg [14:0] us_reg;
  wire tick = (div_reg == TICK_DIV - 7'h01);

  always @(posedge clk_sys_i) begin
    if (rst_i || !any_lpi) begin
      div_reg <= 7'h00;
      us_reg <= 15'h0000;
    end else begin
      div_reg <= tick ? 7'h00 : div_reg + 7'h01;
      if (tick) begin
        us_reg <= (us_reg == PERIOD - 15'h0001) ? 15'h0000 : us_reg + 15'h0001;
      end
    end
  end

  // ==========================================================
  // output flops
  // ==========================================================
  wire norm = state_reg[0];
  wire ovr_spd = in_spd && override && !pll_off_reg;
  wire mac_clk = norm || (ovr_spd && !basic_reg[`PDL_BASIC_ISO]);

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      spd_o <= 1'b0;
      chip_power_down_state_o <= 1'b0;
      int_clk_en_o <= 1'b1;
      pll_on_o <= 1'b1;
      xtal_on_o <= 1'b1;
      regulator_on_o <= 1'b1;
      tx_clk_run_o <= 1'b1;
      rx_clk_run_o <= 1'b1;
      refclk_pin_en_o <= 1'b0;
      reduced_amp_o <= 1'b1;
      eee_en_o <= 1'b1;
      tx_lpi_o <= 1'b0;
      rx_lpi_o <= 1'b0;
      refresh_o <= 1'b0;
      rx_dv_o <= 1'b0;
      rx_er_o <= 1'b0;
      rxd_o <= 8'h00;
    end else begin
      spd_o <= in_spd;
      chip_power_down_state_o <= state_reg[3];
      int_clk_en_o <= norm || ovr_spd;
      pll_on_o <= norm || (in_spd && !pll_off_reg);
      xtal_on_o <= norm || in_spd;
      regulator_on_o <= live && !aux_reg[`PDL_AUX_REG_EN_N];
      tx_clk_run_o <= mac_clk;
      rx_clk_run_o <= mac_clk && !(pcs_ctrl_reg[`PDL_PCS_CLK_STOP] && idle_hit);
      refclk_pin_en_o <= (norm || ovr_spd) && common_reg[`PDL_COMMON_REFCLK_EN];
      reduced_amp_o <= norm && !afed_reg[`PDL_AFED_RED_AMP_DIS];
      eee_en_o <= eee_en_reg;
      tx_lpi_o <= tx_lpi_now;
      rx_lpi_o <= rx_lpi_now;
      refresh_o <= any_lpi && us_reg < BURST;
      if (rx_lpi_now) begin
        rx_dv_o <= 1'b0;
        rx_er_o <= 1'b1;
        rxd_o <= `PDL_LPI_DATA;
      end else begin
        rx_dv_o <= norm && line_dv_i;
        rx_er_o <= norm && line_er_i;
        rxd_o <= norm ? line_data_i : 8'h00;
      end
    end
  end
endmodule

// *** tb/pdl_mac_model.sv ***
// mac-side transmit driver for low-power idle requests.
// assumes clk_i is the system clock; pins change 1 ns after each rising edge.
module pdl_mac_model (
  input wire logic clk_i,
  input wire logic lpi_i,
  output logic tx_en_o,
  output logic tx_er_o,
  output logic [7:0] txd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tx_en_o = 1'b0;
    tx_er_o = 1'b0;
    txd_o = 8'h00;
  end
  // the transmit clock is never stopped, so the nine-cycle hold is kept trivially
  always @(posedge clk_i) begin
    tx_en_o <= #1 1'b0;
    tx_er_o <= #1 lpi_i;
    txd_o <= #1 lpi_i ? 8'h01 : 8'h00;
  end
endmodule

// *** tb/pdl_chk_asserts.sv ***
// port checker of the power-down and low-power idle controller.
// assumes it is bound to pdl_top; everything sampled on clk_sys_i.
module pdl_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic mgmt_req_i,
  input wire logic mgmt_we_i,
  input wire logic mgmt_ext_i,
  input wire logic [4:0] mgmt_mmd_i,
  input wire logic [15:0] mgmt_addr_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic rx_clk_i,
  input wire logic line_sleep_i,
  input wire logic mgmt_ack_o,
  input wire logic mgmt_err_o,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic spd_o,
  input wire logic chip_power_down_state_o,
  input wire logic int_clk_en_o,
  input wire logic xtal_on_o,
  input wire logic tx_clk_run_o,
  input wire logic rx_clk_run_o,
  input wire logic refclk_pin_en_o,
  input wire logic eee_en_o,
  input wire logic tx_lpi_o,
  input wire logic rx_lpi_o,
  input wire logic refresh_o,
  input wire logic rx_dv_o,
  input wire logic rx_er_o,
  input wire logic [7:0] rxd_o
);
  // ==========================================
  // receive clock edges seen during idle
  logic rxc_q;
  logic [7:0] rxc_cnt;
  // the design sees edges through a synchroniser, so allow one edge of slack
  always @(posedge clk_sys_i) begin
    rxc_q <= rx_clk_i;
    if (rst_i || !rx_lpi_o)
      rxc_cnt <= 8'h00;
    else if (rx_clk_i && !rxc_q && rxc_cnt != 8'hFF)
      rxc_cnt <= rxc_cnt + 8'h01;
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_pd_wr(b);
    mgmt_req_i && mgmt_we_i && !mgmt_ext_i && mgmt_addr_i[4:0] == 5'h00
      && mgmt_wdata_i[11] == b;
  endsequence
  sequence s_sleep;
    line_sleep_i && eee_en_o && !spd_o && !chip_power_down_state_o && !rx_lpi_o && !tx_lpi_o;
  endsequence
  a_pd_enter: assert property (s_pd_wr(1'b1) ##0 !chip_power_down_state_o |-> ##[1:4] spd_o)
    else $error("power-down not entered");
  a_pd_leave: assert property (s_pd_wr(1'b0) ##0 spd_o |-> ##[1:4] !spd_o)
    else $error("power-down not left");
  a_ack_next: assert property (mgmt_req_i && !chip_power_down_state_o && xtal_on_o
    |=> mgmt_ack_o) else $error("request not answered next cycle");
  a_ack_cause: assert property (mgmt_ack_o |-> $past(mgmt_req_i))
    else $error("answer without request");
  a_cpd_mute: assert property (chip_power_down_state_o |-> !mgmt_ack_o)
    else $error("answer in chip power-down");
  a_space_one: assert property (mgmt_req_i && mgmt_ext_i && mgmt_mmd_i == 5'h01 && spd_o
    && $past(spd_o) |=> mgmt_err_o && mgmt_rdata_o == 16'h0000)
    else $error("space one reachable in power-down");
  a_clk_gate: assert property (spd_o && (tx_clk_run_o || refclk_pin_en_o) |-> int_clk_en_o)
    else $error("clock runs without override");
  a_rx_sleep: assert property (s_sleep |=> rx_lpi_o && !rx_dv_o && rx_er_o
    && rxd_o == 8'h01 && refresh_o)
    else $error("receive idle signalling wrong");
  a_rx_wake: assert property (rx_lpi_o && !line_sleep_i |=> !rx_lpi_o)
    else $error("receive idle not left");
  a_rx_clk_stop: assert property ($fell(rx_clk_run_o) && !spd_o && !chip_power_down_state_o
    |-> $past(rx_lpi_o) && rxc_cnt >= 8'd8)
    else $error("receive clock stopped early");
  a_refresh_idle: assert property (refresh_o
    |-> tx_lpi_o || rx_lpi_o || $past(tx_lpi_o || rx_lpi_o))
    else $error("refresh outside idle");
endmodule
bind pdl_top pdl_chk u_chk (.*);

// *** tb/tb_top.sv ***
// self-checking bench of the power-down and low-power idle controller.
// assumes the checker is bound to pdl_top and the mac model drives tx pins.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = 40;
  localparam int BUR = 4;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, rx_clk_i = 1'b0, lpi = 1'b0;
  logic [3:0] strap_i = 4'h0;
  logic mgmt_req_i = 1'b0, mgmt_we_i = 1'b0, mgmt_ext_i = 1'b0;
  logic [4:0] mgmt_mmd_i = 5'h00;
  logic [15:0] mgmt_addr_i = 16'h0000, mgmt_wdata_i = 16'h0000, partner_ability_i = 16'h0006;
  logic speed_1000_i = 1'b1, line_sleep_i = 1'b0, line_dv_i = 1'b0, line_er_i = 1'b0;
  logic [7:0] line_data_i = 8'h00, txd_i, rxd_o;
  logic tx_en_i, tx_er_i, mgmt_ack_o, mgmt_err_o, spd_o, chip_power_down_state_o;
  logic int_clk_en_o, pll_on_o, xtal_on_o, regulator_on_o, tx_clk_run_o, rx_clk_run_o;
  logic refclk_pin_en_o, reduced_amp_o, eee_en_o, tx_lpi_o, rx_lpi_o, refresh_o;
  logic rx_dv_o, rx_er_o;
  logic [15:0] mgmt_rdata_o, rd;
  logic er;
  int error_cnt = 0, checks_done = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  always #80 rx_clk_i = ~rx_clk_i;
  pdl_top #(.REFRESH_PERIOD_US(PER), .REFRESH_BURST_US(BUR)) uut (.*);
  pdl_mac_model u_mac (.clk_i(clk_sys_i), .lpi_i(lpi), .tx_en_o(tx_en_i),
    .tx_er_o(tx_er_i), .txd_o(txd_i));
  // ==========================================
  // shared tasks
  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wt(ref logic s, input logic v, input int n, input string m);
    repeat (n) begin
      if (s === v)
        return;
      tick(1);
    end
    chk(s, v, m);
    stop_test();
  endtask
  task automatic acc(input logic w, x, input logic [4:0] m, input logic [15:0] a, d);
    mgmt_req_i = 1'b1;
    mgmt_we_i = w;
    mgmt_ext_i = x;
    mgmt_mmd_i = m;
    mgmt_addr_i = a;
    mgmt_wdata_i = d;
    tick(1);
    mgmt_req_i = 1'b0;
    rd = mgmt_rdata_o;
    er = mgmt_err_o;
    chk(mgmt_ack_o, 1'b1, "ack");
    // spare edge so a following request never re-raises req in the same step
    tick(1);
  endtask
  task automatic rst(input logic [3:0] s);
    strap_i = s;
    rst_i = 1'b1;
    tick(4);
    rst_i = 1'b0;
    tick(6);
  endtask
  task automatic pd(input logic [15:0] d, input logic v);
    acc(1, 0, 0, 0, d);
    wt(spd_o, v, 8, "spd");
  endtask
  task automatic mute();
    mgmt_req_i = 1'b1;
    tick(1);
    mgmt_req_i = 1'b0;
    chk(mgmt_ack_o, 0, "mute");
    tick(1);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    chk({eee_en_o, reduced_amp_o, regulator_on_o, refclk_pin_en_o}, 4'hF, "rst");
    acc(0, 1, 7, 16'h003C, 0);
    chk(rd, 16'h0006, "adv");
    acc(0, 1, 7, 16'h003D, 0);
    chk(rd, 16'h0006, "lpa");
    acc(1, 1, 3, 16'h0001, 16'hFFFF);
    acc(0, 1, 3, 16'h0001, 0);
    chk(rd, 16'h0000, "status ro");
    acc(0, 1, 3, 16'h0055, 0);
    chk(rd, 16'h0000, "unmapped");
    acc(1, 1, 2, 16'h0012, 1);
    tick(2);
    chk(reduced_amp_o, 0, "red amp");
  endtask
  task automatic t_spd();
    acc(1, 1, 7, 16'h003C, 16'h0004);
    pd(16'h0800, 1);
    chk({int_clk_en_o, tx_clk_run_o, rx_clk_run_o, refclk_pin_en_o}, 0, "gate");
    chk({pll_on_o, xtal_on_o, regulator_on_o}, 3'h7, "on");
    acc(0, 1, 3, 0, 0);
    chk(er, 1, "ext err");
    acc(0, 0, 0, 0, 0);
    chk({er, rd[11]}, 2'b01, "std ok");
    acc(1, 0, 0, 16'h001B, 16'h0002);
    tick(2);
    chk(regulator_on_o, 0, "reg off");
    acc(1, 0, 0, 16'h001B, 0);
    pd(0, 0);
    acc(0, 1, 7, 16'h003C, 0);
    chk(rd, 16'h0004, "kept");
  endtask
  task automatic t_ovr();
    acc(1, 1, 2, 16'h0010, 1);
    pd(16'h0800, 1);
    chk({int_clk_en_o, tx_clk_run_o, refclk_pin_en_o}, 3'h7, "ovr");
    acc(0, 1, 3, 0, 0);
    chk(er, 0, "ovr ext");
    acc(0, 1, 1, 0, 0);
    chk(er, 1, "space1");
    acc(1, 0, 0, 0, 16'h0C00);
    tick(3);
    chk({tx_clk_run_o, rx_clk_run_o}, 0, "iso");
    pd(0, 0);
  endtask
  task automatic t_pll();
    acc(1, 1, 2, 16'h0010, 2);
    pd(16'h0800, 1);
    chk({pll_on_o, int_clk_en_o}, 0, "pll");
    pd(0, 0);
    tick(3);
    acc(0, 1, 7, 16'h003C, 0);
    chk(rd, 16'h0006, "full rst");
    acc(0, 1, 2, 16'h0010, 0);
    chk(rd, 0, "spd ctl rst");
  endtask
  task automatic t_tx();
    int n;
    lpi = 1'b1;
    wt(tx_lpi_o, 1, 10, "tx lpi");
    speed_1000_i = 1'b0;
    acc(0, 1, 3, 1, 0);
    chk(rd[9:8], 2'b10, "tx only");
    chk(tx_lpi_o, 1, "tx mii");
    chk(tx_clk_run_o, 1, "txc");
    wt(refresh_o, 0, 500, "burst end");
    n = 0;
    while (refresh_o === 1'b0 && n < 9000) begin
      n++;
      tick(1);
    end
    chk(n, (PER - BUR) * 100, "quiet");
    if (n == 9000)
      stop_test();
    n = 0;
    while (refresh_o === 1'b1 && n < 9000) begin
      n++;
      tick(1);
    end
    chk(n, BUR * 100, "burst");
    if (n == 9000)
      stop_test();
    lpi = 1'b0;
    tick(6);
    chk({tx_lpi_o, refresh_o}, 0, "tx wake");
    speed_1000_i = 1'b1;
  endtask
  task automatic t_rx();
    acc(1, 1, 3, 0, 16'h0400);
    line_sleep_i = 1'b1;
    tick(1);
    chk({rx_lpi_o, rx_dv_o, rx_er_o, rxd_o}, 11'h501, "rx lpi");
    chk({tx_lpi_o, rx_clk_run_o}, 2'b01, "rx only");
    wt(rx_clk_run_o, 0, 400, "rxc stop");
    line_sleep_i = 1'b0;
    line_dv_i = 1'b1;
    line_data_i = 8'hA5;
    tick(1);
    chk({rx_lpi_o, rx_dv_o, rxd_o}, 10'h1A5, "rx wake");
    line_dv_i = 1'b0;
  endtask
  task automatic t_eee();
    acc(1, 1, 7, 16'h003C, 0);
    acc(1, 0, 0, 0, 16'h0200);
    tick(3);
    chk(eee_en_o, 0, "eee off");
    line_sleep_i = 1'b1;
    tick(2);
    chk(rx_lpi_o, 0, "no lpi");
    line_sleep_i = 1'b0;
  endtask
  task automatic t_dead();
    acc(1, 1, 2, 16'h0010, 2);
    pd(16'h0800, 1);
    acc(1, 0, 0, 16'h001B, 1);
    tick(3);
    chk({pll_on_o, xtal_on_o}, 0, "xtal off");
    mute();
  endtask
  task automatic t_cpd();
    rst(4'h7);
    chk(chip_power_down_state_o, 1, "cpd");
    mute();
    rst(4'h0);
    chk(chip_power_down_state_o, 0, "cpd left");
  endtask
  initial begin
    rst(4'h0);
    t_reset();
    t_spd();
    t_ovr();
    t_pll();
    t_tx();
    t_rx();
    t_eee();
    t_dead();
    t_cpd();
    stop_test();
  end
endmodule
